// file: design/prio_irq_cfg.svh
`ifndef PRIO_IRQ_CFG_SVH
`define PRIO_IRQ_CFG_SVH

// ----------------------------------------------------------------------------
// Source numbering (also the tie-break polling order, 0 polled first)
// ----------------------------------------------------------------------------
`define IRQ_NUM_SRC 13
`define IRQ_SRC_W 4
`define IRQ_SRC_EXT0 4'h0
`define IRQ_SRC_EXT1 4'h2
`define IRQ_SRC_NONE 4'hF

// ----------------------------------------------------------------------------
// Register layout
// ----------------------------------------------------------------------------
`define IRQ_REG_W 8
`define IRQ_GLOBAL_BIT 7
`define IRQ_LVL_W 2
`define IRQ_LVL_TOP 2'h3
`define IRQ_LVL_ZERO 2'h0
`define IRQ_NEST_W 4
`define IRQ_REG_RST 8'h00
`define IRQ_SRC_RST 13'h0000

// ----------------------------------------------------------------------------
// Timer control register bit positions
// ----------------------------------------------------------------------------
`define TCR_IT0_BIT 0
`define TCR_IE0_BIT 1
`define TCR_IT1_BIT 2
`define TCR_IE1_BIT 3

`endif

// file: design/prio_irq_pkg.sv
package prio_irq_pkg;
  typedef enum logic [1:0]
  {
    ARB_IDLE = 2'b00,
    ARB_REQ = 2'b01,
    ARB_SERVE = 2'b11
  } arb_state_e;

  typedef logic [1:0] level_t;
endpackage : prio_irq_pkg

// file: design/ext_irq_detect.sv
`timescale 1ns/1ps
`include "prio_irq_cfg.svh"

module ext_irq_detect
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Pin and mode
  input wire logic extIrqPin,
  input wire logic edgeMode,
  input wire logic flagClear,
  // Result
  output logic extRequestFlag,
  output logic request
);
  logic pinPrev_ff;
  logic flag_ff;

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      pinPrev_ff <= 1'b1;
    else
      pinPrev_ff <= extIrqPin;
  end

  // Set wins over the service clear so a fresh edge is never lost
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      flag_ff <= 1'b0;
    else if (!edgeMode)
      flag_ff <= !extIrqPin;
    else if (pinPrev_ff && !extIrqPin)
      flag_ff <= 1'b1;
    else if (flagClear)
      flag_ff <= 1'b0;
  end

  assign extRequestFlag = flag_ff;
  // Level mode follows the pin so the request holds while it stays low
  assign request = edgeMode ? flag_ff : !extIrqPin;
endmodule : ext_irq_detect

// file: design/prioritized_interrupt_controller.sv
//
// Contract
// - Thirteen request sources: pins, timers, serial, brownout, watchdog, bus, keys, etc.
// - Each source has its own enable bit across two enable registers.
// - Global enable bit clear blocks every source from the core.
// - Four priority levels from paired low and high priority register bits.
// - Active routine preempted only by strictly higher priority request.
// - Routine at highest level is never preempted.
// - Pending checked each instruction start; fixed polling order breaks ties.
// - Per-pin trigger-type bit selects level or falling-edge detection.
// - Edge mode sets request flag on high sample then low sample.
// - Enabled external interrupt wakes core from Power-down or Idle.
// - Any enabled source or reset ends Idle mode.
//
`timescale 1ns/1ps
`include "prio_irq_cfg.svh"

module prioritized_interrupt_controller
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Register contents from the core
  input wire logic [7:0] irq_enable_reg_a,
  input wire logic [7:0] irq_enable_reg_b,
  input wire logic [7:0] priority_low_reg_a,
  input wire logic [7:0] priority_high_reg_a,
  input wire logic [7:0] priority_low_reg_b,
  input wire logic [7:0] priority_high_reg_b,
  input wire logic ext0_trigger_type,
  input wire logic ext1_trigger_type,
  // Peripheral request lines, index 0 and 2 unused (external pins)
  input wire logic [12:0] periphReq,
  input wire logic [1:0] ext_irq_pin,
  // Core handshake
  input wire logic instrStart,
  input wire logic serviceAck,
  input wire logic serviceReturn,
  input wire logic idleMode,
  input wire logic powerDownMode,
  // Results
  output logic irqReq_ff,
  output logic [3:0] irqSrc_ff,
  output logic [1:0] irqLevel_ff,
  output logic wakeUp_ff,
  output logic [1:0] ext_request_flag_ff,
  output logic [7:0] timer_control_reg_ff,
  output logic [3:0] activeLevels_ff
);
  // --------------------------------------------------------------------------
  // External pin detection
  // --------------------------------------------------------------------------
  logic [1:0] extReq;
  logic [1:0] extFlag;
  logic [1:0] extClear;

  assign extClear[0] = serviceAck && (irqSrc_ff == `IRQ_SRC_EXT0);
  assign extClear[1] = serviceAck && (irqSrc_ff == `IRQ_SRC_EXT1);

  ext_irq_detect u_ext0
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .extIrqPin(ext_irq_pin[0]),
    .edgeMode(ext0_trigger_type),
    .flagClear(extClear[0]),
    .extRequestFlag(extFlag[0]),
    .request(extReq[0])
  );

  ext_irq_detect u_ext1
  (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .extIrqPin(ext_irq_pin[1]),
    .edgeMode(ext1_trigger_type),
    .flagClear(extClear[1]),
    .extRequestFlag(extFlag[1]),
    .request(extReq[1])
  );

  // --------------------------------------------------------------------------
  // Source gathering and enables
  // --------------------------------------------------------------------------
  logic [12:0] rawReq;
  logic [12:0] enables;
  logic [12:0] pending;

  always_comb
  begin
    rawReq = periphReq;
    rawReq[`IRQ_SRC_EXT0] = extReq[0];
    rawReq[`IRQ_SRC_EXT1] = extReq[1];
  end

  // Bit 7 of enable reg a is the global enable, not a source
  assign enables = {irq_enable_reg_b[5:0], irq_enable_reg_a[6:0]};
  assign pending = rawReq & enables;

  // --------------------------------------------------------------------------
  // Priority level per source
  // --------------------------------------------------------------------------
  function automatic prio_irq_pkg::level_t srcLevel(input logic [3:0] idx);
    logic [15:0] lowBits;
    logic [15:0] highBits;
    lowBits = {priority_low_reg_b, priority_low_reg_a};
    highBits = {priority_high_reg_b, priority_high_reg_a};
    srcLevel = {highBits[idx], lowBits[idx]};
  endfunction : srcLevel

  // Strict compare keeps an equal level from preempting or reordering
  function automatic logic lvlAbove
  (
    input prio_irq_pkg::level_t a,
    input prio_irq_pkg::level_t b
  );
    lvlAbove = (a > b);
  endfunction : lvlAbove

  // --------------------------------------------------------------------------
  // Level table, one entry per source
  // --------------------------------------------------------------------------
  prio_irq_pkg::level_t srcLvl [`IRQ_NUM_SRC];

  always_comb
  begin
    for (int i = 0; i < `IRQ_NUM_SRC; i++)
    begin
      srcLvl[i] = srcLevel(4'(i));
    end
  end

  // --------------------------------------------------------------------------
  // Arbitration
  // --------------------------------------------------------------------------
  logic [3:0] winSrc;
  prio_irq_pkg::level_t winLevel;
  logic winValid;
  logic [3:0] curTop;
  logic curValid;
  logic canPreempt;

  // Higher level first; equal level keeps the lower index (polling order)
  always_comb
  begin
    winSrc = `IRQ_SRC_NONE;
    winLevel = `IRQ_LVL_ZERO;
    winValid = 1'b0;
    for (int i = 0; i < `IRQ_NUM_SRC; i++)
    begin
      if (pending[i] && (!winValid || lvlAbove(srcLvl[i], winLevel)))
      begin
        winSrc = 4'(i);
        winLevel = srcLvl[i];
        winValid = 1'b1;
      end
    end
  end

  // Highest level currently in service
  always_comb
  begin
    curTop = 4'h0;
    curValid = 1'b0;
    for (int l = 0; l < `IRQ_NEST_W; l++)
    begin
      if (activeLevels_ff[l])
      begin
        curTop = 4'(l);
        curValid = 1'b1;
      end
    end
  end

  // A top-level routine blocks all; otherwise need strictly higher level
  assign canPreempt = !curValid ||
    ((curTop[1:0] != `IRQ_LVL_TOP) && lvlAbove(winLevel, curTop[1:0]));

  // --------------------------------------------------------------------------
  // Request state machine
  // --------------------------------------------------------------------------
  prio_irq_pkg::arb_state_e state_ff;
  prio_irq_pkg::arb_state_e nxt_state;
  logic grant;

  assign grant = instrStart && winValid && canPreempt &&
    irq_enable_reg_a[`IRQ_GLOBAL_BIT];

  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      prio_irq_pkg::ARB_IDLE:
      begin
        if (grant)
          nxt_state = prio_irq_pkg::ARB_REQ;
      end
      prio_irq_pkg::ARB_REQ:
      begin
        if (serviceAck)
          nxt_state = prio_irq_pkg::ARB_SERVE;
        else if (!irq_enable_reg_a[`IRQ_GLOBAL_BIT])
          nxt_state = prio_irq_pkg::ARB_IDLE;
      end
      prio_irq_pkg::ARB_SERVE:
      begin
        nxt_state = prio_irq_pkg::ARB_IDLE;
      end
      default:
      begin
        nxt_state = prio_irq_pkg::ARB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      state_ff <= prio_irq_pkg::ARB_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Request outputs latch the winner so the core sees a stable vector
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      irqReq_ff <= 1'b0;
      irqSrc_ff <= `IRQ_SRC_NONE;
      irqLevel_ff <= `IRQ_LVL_ZERO;
    end
    else if (state_ff == prio_irq_pkg::ARB_IDLE && grant)
    begin
      irqReq_ff <= 1'b1;
      irqSrc_ff <= winSrc;
      irqLevel_ff <= winLevel;
    end
    else if (nxt_state != prio_irq_pkg::ARB_REQ)
    begin
      irqReq_ff <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Nesting record
  // --------------------------------------------------------------------------
  logic [3:0] retMask;

  // Return clears only the highest level in service
  always_comb
  begin
    retMask = 4'h0;
    if (curValid)
      retMask[curTop[1:0]] = 1'b1;
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      activeLevels_ff <= 4'h0;
    else if (serviceAck && state_ff == prio_irq_pkg::ARB_REQ)
    begin
      activeLevels_ff <= activeLevels_ff | (4'h1 << irqLevel_ff);
    end
    else if (serviceReturn)
    begin
      activeLevels_ff <= activeLevels_ff & ~retMask;
    end
  end

  // --------------------------------------------------------------------------
  // Wake-up and visible flags
  // --------------------------------------------------------------------------
  // Wake ignores the global enable, so sleep with it clear still resumes
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      wakeUp_ff <= 1'b0;
    else
      wakeUp_ff <= (idleMode && |pending) ||
        (powerDownMode && |(extReq & {enables[`IRQ_SRC_EXT1], enables[`IRQ_SRC_EXT0]}));
  end

  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
      ext_request_flag_ff <= 2'b00;
    else
      ext_request_flag_ff <= extFlag;
  end

  // Unused timer bits read as zero; only the pin fields live here
  always_ff @(posedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      timer_control_reg_ff <= `IRQ_REG_RST;
    end
    else
    begin
      timer_control_reg_ff <= `IRQ_REG_RST;
      timer_control_reg_ff[`TCR_IT0_BIT] <= ext0_trigger_type;
      timer_control_reg_ff[`TCR_IE0_BIT] <= extFlag[0];
      timer_control_reg_ff[`TCR_IT1_BIT] <= ext1_trigger_type;
      timer_control_reg_ff[`TCR_IE1_BIT] <= extFlag[1];
    end
  end
endmodule : prioritized_interrupt_controller

// file: dv/core_model.sv
`timescale 1ns/1ps
module core_model
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Handshake
  input wire logic irqReq_ff,
  input wire logic ackOn,
  output logic instrStart,
  output logic serviceAck
);
  // Boundary every other cycle; ackOn low stands for a slow core
  always_ff @(negedge clk_sys or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      instrStart <= 1'h0;
      serviceAck <= 1'h0;
    end
    else
    begin
      instrStart <= ~instrStart;
      serviceAck <= irqReq_ff & ackOn & ~serviceAck;
    end
  end
endmodule : core_model

// file: dv/prioritized_interrupt_controller_props.sv
`timescale 1ns/1ps
module prioritized_interrupt_controller_props
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // Inputs
  input wire logic [7:0] irq_enable_reg_a,
  input wire logic ext0_trigger_type,
  input wire logic [1:0] ext_irq_pin,
  input wire logic instrStart,
  input wire logic serviceAck,
  input wire logic idleMode,
  input wire logic powerDownMode,
  // Outputs
  input wire logic irqReq_ff,
  input wire logic [3:0] irqSrc_ff,
  input wire logic [1:0] irqLevel_ff,
  input wire logic wakeUp_ff,
  input wire logic [1:0] ext_request_flag_ff,
  input wire logic [3:0] activeLevels_ff
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_grant_needs_global: assert property ($rose(irqReq_ff) |->
    $past(irq_enable_reg_a[7] & instrStart)) else $error("Grant without enable");
  a_ack_drops_req: assert property (irqReq_ff && serviceAck |=> !irqReq_ff)
    else $error("Request held after ack");
  a_ack_marks_level: assert property (irqReq_ff && serviceAck |=>
    activeLevels_ff[$past(irqLevel_ff)]) else $error("Level not marked active");
  a_strict_preempt: assert property ($rose(irqReq_ff) |->
    ($past(activeLevels_ff) >> irqLevel_ff) == 4'h0) else $error("Preempt not higher");
  a_top_no_preempt: assert property (activeLevels_ff[3] |=> !$rose(irqReq_ff))
    else $error("Top level preempted");
  a_wake_in_sleep: assert property ($rose(wakeUp_ff) |->
    $past(idleMode | powerDownMode)) else $error("Wake outside sleep");
  a_level_flag: assert property ((!ext0_trigger_type && !ext_irq_pin[0])[*4] |=>
    ext_request_flag_ff[0]) else $error("Level flag missing");
  a_edge_cleared: assert property (irqReq_ff && serviceAck && irqSrc_ff == 4'h0
    && ext0_trigger_type && $past(ext_irq_pin[0], 2) == 1'h0 && $past(ext_irq_pin[0]) == 1'h0
    && !ext_irq_pin[0] ##1 ext0_trigger_type |=> !ext_request_flag_ff[0])
    else $error("Edge flag not cleared");
endmodule : prioritized_interrupt_controller_props

bind prioritized_interrupt_controller prioritized_interrupt_controller_props u_props (.*);

// file: dv/prioritized_interrupt_controller_bench.sv
`timescale 1ns/1ps
module prioritized_interrupt_controller_bench;
  logic clk_sys = 1'h0;
  logic sys_rst = 1'h1;
  logic [7:0] irq_enable_reg_a = 8'h00, irq_enable_reg_b = 8'h00;
  logic [7:0] priority_low_reg_a = 8'h00, priority_high_reg_a = 8'h00;
  logic [7:0] priority_low_reg_b = 8'h00, priority_high_reg_b = 8'h00;
  logic ext0_trigger_type = 1'h0, ext1_trigger_type = 1'h0, serviceReturn = 1'h0;
  logic idleMode = 1'h0, powerDownMode = 1'h0, ackOn = 1'h1, prevReq = 1'h0;
  logic [12:0] periphReq = 13'h0000;
  logic [1:0] ext_irq_pin = 2'h3;
  logic instrStart, serviceAck, irqReq_ff, wakeUp_ff;
  logic [3:0] irqSrc_ff, activeLevels_ff;
  logic [1:0] irqLevel_ff, ext_request_flag_ff;
  logic [7:0] timer_control_reg_ff;
  logic [7:0] rnd = 8'h5A;
  logic [5:0] expQ [$];
  int mismatches = 0;
  int checks = 0;

  always #20 clk_sys = ~clk_sys;
  prioritized_interrupt_controller u_dut (.*);
  core_model u_core (.*);

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    lfsr = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // Enables, sets the level and raises the request of one source
  task automatic setSrc(input int s, input logic [1:0] l);
    if (s < 7) irq_enable_reg_a[s] = 1'h1;
    else irq_enable_reg_b[s-7] = 1'h1;
    if (s < 8) {priority_high_reg_a[s], priority_low_reg_a[s]} = l;
    else {priority_high_reg_b[s-8], priority_low_reg_b[s-8]} = l;
    if (s == 0 || s == 2) ext_irq_pin[s/2] = 1'h0;
    else periphReq[s] = 1'h1;
  endtask : setSrc

  // Four returns empty the in-service set whatever was nested
  task automatic clr;
    periphReq = 13'h0000;
    ext_irq_pin = 2'h3;
    irq_enable_reg_a[6:0] = 7'h00;
    irq_enable_reg_b = 8'h00;
    repeat (4)
    begin
      @(negedge clk_sys);
      serviceReturn = 1'h1;
      @(negedge clk_sys);
      serviceReturn = 1'h0;
    end
  endtask : clr

  task automatic endCase;
    for (int n = 0; n < 40 && expQ.size() > 0; n++)
      @(negedge clk_sys);
    chk(8'(expQ.size()), 8'h00);
    clr();
    chk({4'h0, activeLevels_ff}, 8'h00);
  endtask : endCase

  // A grant with no note waiting is an unexpected grant
  always @(negedge clk_sys)
  begin
    prevReq <= irqReq_ff;
    if (irqReq_ff === 1'h1 && prevReq === 1'h0)
      chk({2'h0, irqSrc_ff, irqLevel_ff}, expQ.size() > 0 ? {2'h0, expQ.pop_front()} : 8'hFF);
  end

  initial
  begin
    repeat (4000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end

  initial
  begin
    repeat (5) @(negedge clk_sys);
    sys_rst = 1'h0;
    irq_enable_reg_a[7] = 1'h1;
    for (int s = 0; s < 13; s++)
    begin
      rnd = lfsr(rnd);
      expQ.push_back({s[3:0], rnd[1:0]});
      setSrc(s, rnd[1:0]);
      endCase();
    end
    ackOn = 1'h0;
    expQ.push_back({4'h4, 2'h1});
    setSrc(9, 2'h1);
    setSrc(4, 2'h1);
    repeat (6) @(negedge clk_sys);
    ackOn = 1'h1;
    repeat (6) @(negedge clk_sys);
    expQ.push_back({4'hC, 2'h2});
    setSrc(12, 2'h2);
    repeat (8) @(negedge clk_sys);
    chk({4'h0, activeLevels_ff}, 8'h06);
    endCase();
    expQ.push_back({4'hB, 2'h3});
    setSrc(1, 2'h0);
    setSrc(11, 2'h3);
    repeat (8) @(negedge clk_sys);
    chk({4'h0, activeLevels_ff}, 8'h08);
    endCase();
    irq_enable_reg_a[7] = 1'h0;
    setSrc(3, 2'h2);
    periphReq[5] = 1'h1;
    {priority_high_reg_a[5], priority_low_reg_a[5]} = 2'h3;
    repeat (8) @(negedge clk_sys);
    expQ.push_back({4'h3, 2'h2});
    irq_enable_reg_a[7] = 1'h1;
    endCase();
    ext0_trigger_type = 1'h1;
    irq_enable_reg_a[7] = 1'h0;
    setSrc(0, 2'h1);
    repeat (4) @(negedge clk_sys);
    chk({4'h0, timer_control_reg_ff[3:0]}, 8'h03);
    chk({6'h00, ext_request_flag_ff}, 8'h01);
    expQ.push_back({4'h0, 2'h1});
    irq_enable_reg_a[7] = 1'h1;
    repeat (8) @(negedge clk_sys);
    chk({4'h0, timer_control_reg_ff[3:0]}, 8'h01);
    endCase();
    ext0_trigger_type = 1'h0;
    irq_enable_reg_a[7] = 1'h0;
    idleMode = 1'h1;
    setSrc(3, 2'h1);
    repeat (3) @(negedge clk_sys);
    chk({7'h00, wakeUp_ff}, 8'h01);
    clr();
    idleMode = 1'h0;
    powerDownMode = 1'h1;
    setSrc(7, 2'h1);
    repeat (3) @(negedge clk_sys);
    chk({7'h00, wakeUp_ff}, 8'h00);
    setSrc(2, 2'h1);
    repeat (3) @(negedge clk_sys);
    chk({7'h00, wakeUp_ff}, 8'h01);
    summarize();
  end
endmodule : prioritized_interrupt_controller_bench
